// ### inc/i2c_access_pkg.sv
// Shared constants and types for the two-wire register access port.
// Assumes both ends run on one 50 MHz system clock.
package i2c_access_pkg;
	// ************************************************************
	// Timing
	// ************************************************************
	localparam int CLK_HZ         = 50_000_000;
	localparam int SCL_HZ         = 100_000;
	localparam int QUARTER_CYCLES = CLK_HZ / (4 * SCL_HZ);

	// ************************************************************
	// Framing
	// ************************************************************
	localparam logic [3:0] BITS_PER_BYTE  = 4'h8;
	localparam logic [3:0] BITS_PER_FRAME = 4'h9;
	localparam logic [6:0] DEFAULT_SLAVE  = 7'h50;

	// ************************************************************
	// Device register map
	// ************************************************************
	localparam logic [15:0] CTRL_ADDR      = 16'h0000;
	localparam logic [15:0] REVISION_ADDR  = 16'h000A;
	localparam logic [15:0] USER_BASE      = 16'h0010;
	localparam int          USER_COUNT     = 8;
	localparam logic [7:0]  CTRL_RESET     = 8'h00;
	localparam logic [7:0]  USER_RESET     = 8'h00;
	localparam int          SDO_ENABLE_BIT = 7;
	localparam int          LSB_FIRST_BIT  = 6;
	localparam int          DESCEND_BIT    = 5;
	localparam int          SOFT_RESET_BIT = 4;
	localparam logic [7:0]  SOFT_RESET_MASK = 8'h10;

	// ************************************************************
	// Host command port map
	// ************************************************************
	localparam logic [2:0] HOST_CMD    = 3'h0;
	localparam logic [2:0] HOST_ADDR_H = 3'h1;
	localparam logic [2:0] HOST_ADDR_L = 3'h2;
	localparam logic [2:0] HOST_WDATA  = 3'h3;
	localparam logic [2:0] HOST_STATUS = 3'h4;
	localparam logic [2:0] HOST_RDATA  = 3'h5;
	localparam int         STATUS_BUSY = 0;
	localparam int         STATUS_NACK = 1;

	typedef enum logic [1:0] {OP_WRITE, OP_SET_ADDR, OP_READ_CUR, OP_COMBINED} host_op_t;
	typedef enum {K_SLA_W, K_ADDR_HI, K_ADDR_LO, K_DATA_W, K_RSTART, K_SLA_R, K_DATA_R, K_STOP} step_kind_t;
	typedef enum {H_IDLE, H_START, H_BIT, H_STOP} host_state_t;
	typedef enum {D_IDLE, D_SLAVE, D_ADDR_HI, D_ADDR_LO, D_WRITE, D_READ} dev_state_t;
endpackage

// ### inc/i2c_link_if.sv
// Two-wire link joining the register port and its bus master.
// Both lines are open drain with pull-ups; the wire level is resolved here.
`timescale 1ns/1ps
interface i2c_link_if;
	logic sclHostOut;
	logic sclHostOe;
	logic sdaHostOut;
	logic sdaHostOe;
	logic sdaDevOut;
	logic sdaDevOe;
	logic scl;
	logic sda;

	// Pull-up wins unless an enabled driver pulls low
	assign scl = !(sclHostOe && !sclHostOut);
	assign sda = !((sdaHostOe && !sdaHostOut) || (sdaDevOe && !sdaDevOut));

	modport device (input scl, input sda, output sdaDevOut, output sdaDevOe);
	modport host (input scl, input sda, output sclHostOut, output sclHostOe, output sdaHostOut, output sdaHostOe);
endinterface

// ### src/sync_two_stage.sv
// Two flip-flop synchroniser for asynchronous pin levels.
// Assumes a single system clock; idle level given by RESET_VALUE.
`timescale 1ns/1ps
module sync_two_stage #(
	parameter int               WIDTH       = 2,
	parameter logic [WIDTH-1:0] RESET_VALUE = '1
) (
	input  wire logic             sys_clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] meta_reg;

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			meta_reg <= RESET_VALUE;
			dout     <= RESET_VALUE;
		end
		else
		begin
			meta_reg <= din;
			dout     <= meta_reg;
		end
	end
endmodule

// ### src/i2c_port_device.sv
// Slave register port: 16-bit addressed register space over the two-wire link.
// Assumes the link lines are asynchronous and are sampled on sys_clk.
`timescale 1ns/1ps
module i2c_port_device #(
	parameter logic [6:0] SLAVE_ADDR  = i2c_access_pkg::DEFAULT_SLAVE,
	parameter logic [7:0] SILICON_REV = 8'h3C // Arbitrary value
) (
	input  wire logic                                        sys_clk,
	input  wire logic                                        rst,
	i2c_link_if.device                                       link,
	output logic      [7:0]                                  controlValue,
	output logic                                             softResetPulse,
	output logic      [i2c_access_pkg::USER_COUNT-1:0][7:0]  userRegs,
	output logic                                             busy
);
	// ************************************************************
	// Pin sampling and bus conditions
	// ************************************************************
	logic [1:0] pinSync;
	logic       sclPrev_reg;
	logic       sdaPrev_reg;
	logic       sclNow;
	logic       sdaNow;
	logic       startSeen;
	logic       stopSeen;
	logic       sclRise;
	logic       sclFall;

	sync_two_stage #(
		.WIDTH       (2),
		.RESET_VALUE (2'h3)
	) u_pin_sync (
		.sys_clk (sys_clk),
		.rst     (rst),
		.din     ({link.scl, link.sda}),
		.dout    (pinSync)
	);

	assign sclNow    = pinSync[1];
	assign sdaNow    = pinSync[0];
	assign startSeen = sclNow && sclPrev_reg && sdaPrev_reg && !sdaNow;
	assign stopSeen  = sclNow && sclPrev_reg && !sdaPrev_reg && sdaNow;
	assign sclRise   = sclNow && !sclPrev_reg;
	assign sclFall   = !sclNow && sclPrev_reg;

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			sclPrev_reg <= 1'b1;
			sdaPrev_reg <= 1'b1;
		end
		else
		begin
			sclPrev_reg <= sclNow;
			sdaPrev_reg <= sdaNow;
		end
	end

	// ************************************************************
	// Bit framing
	// ************************************************************
	i2c_access_pkg::dev_state_t state_reg;
	logic [3:0]  bitCnt_reg;
	logic [7:0]  rxShift_reg;
	logic [7:0]  txShift_reg;
	logic        ackIn_reg;
	logic        sdaOe_reg;
	logic [15:0] ptr_reg;
	logic [7:0]  addrHigh_reg;
	logic [7:0]  ctrl_reg;
	logic        softPulse_reg;
	logic [i2c_access_pkg::USER_COUNT-1:0][7:0] user_reg;
	logic        byteDone;
	logic        slotDone;
	logic        addrMatch;
	logic        writeEn;
	logic        readLoad;
	logic [15:0] nextPtr;
	logic [7:0]  readValue;
	logic [15:0] userOffset;
	logic        userHit;

	assign byteDone  = sclFall && bitCnt_reg == i2c_access_pkg::BITS_PER_BYTE;
	assign slotDone  = sclFall && bitCnt_reg == i2c_access_pkg::BITS_PER_FRAME;
	assign addrMatch = rxShift_reg[7:1] == SLAVE_ADDR;
	// Bytes reach registers only when complete, so a cut byte is dropped
	assign writeEn   = byteDone && state_reg == i2c_access_pkg::D_WRITE;
	// Own ACK on the address slot reads back low, so the first load follows it
	assign readLoad  = slotDone && state_reg == i2c_access_pkg::D_READ && !ackIn_reg;
	assign nextPtr   = ctrl_reg[i2c_access_pkg::DESCEND_BIT] ? ptr_reg - 16'h0001 : ptr_reg + 16'h0001;
	assign userOffset = ptr_reg - i2c_access_pkg::USER_BASE;
	assign userHit   = ptr_reg >= i2c_access_pkg::USER_BASE
		&& userOffset < 16'(i2c_access_pkg::USER_COUNT);

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			bitCnt_reg <= 4'h0;
		else if (startSeen || stopSeen || slotDone)
			bitCnt_reg <= 4'h0;
		else if (sclRise && state_reg != i2c_access_pkg::D_IDLE)
			bitCnt_reg <= bitCnt_reg + 4'h1;
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			rxShift_reg <= 8'h00;
			ackIn_reg   <= 1'b1;
		end
		else if (sclRise && bitCnt_reg < i2c_access_pkg::BITS_PER_BYTE)
			rxShift_reg <= {rxShift_reg[6:0], sdaNow};
		else if (sclRise)
			ackIn_reg <= sdaNow;
	end

	// ************************************************************
	// Transfer sequencing
	// ************************************************************
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			state_reg <= i2c_access_pkg::D_IDLE;
		else if (startSeen)
			state_reg <= i2c_access_pkg::D_SLAVE;
		else if (stopSeen)
			state_reg <= i2c_access_pkg::D_IDLE;
		else if (byteDone)
		begin
			unique case (state_reg)
				i2c_access_pkg::D_SLAVE:
					if (!addrMatch)
						state_reg <= i2c_access_pkg::D_IDLE;
					else if (rxShift_reg[0])
						state_reg <= i2c_access_pkg::D_READ;
					else
						state_reg <= i2c_access_pkg::D_ADDR_HI;
				i2c_access_pkg::D_ADDR_HI: state_reg <= i2c_access_pkg::D_ADDR_LO;
				i2c_access_pkg::D_ADDR_LO: state_reg <= i2c_access_pkg::D_WRITE;
				default: state_reg <= state_reg;
			endcase
		end
		else if (slotDone && state_reg == i2c_access_pkg::D_READ && ackIn_reg)
			state_reg <= i2c_access_pkg::D_IDLE;
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			ptr_reg      <= 16'h0000;
			addrHigh_reg <= 8'h00;
		end
		else if (byteDone && state_reg == i2c_access_pkg::D_ADDR_HI)
			addrHigh_reg <= rxShift_reg;
		else if (byteDone && state_reg == i2c_access_pkg::D_ADDR_LO)
			ptr_reg <= {addrHigh_reg, rxShift_reg};
		else if (writeEn || readLoad)
			ptr_reg <= nextPtr;
	end

	// Open-drain data: only ever pulls low, changed while SCL is low
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			sdaOe_reg   <= 1'b0;
			txShift_reg <= 8'h00;
		end
		else if (startSeen || stopSeen)
			sdaOe_reg <= 1'b0;
		else if (byteDone)
		begin
			unique case (state_reg)
				i2c_access_pkg::D_SLAVE: sdaOe_reg <= addrMatch;
				i2c_access_pkg::D_ADDR_HI,
				i2c_access_pkg::D_ADDR_LO,
				i2c_access_pkg::D_WRITE: sdaOe_reg <= 1'b1;
				default: sdaOe_reg <= 1'b0;
			endcase
		end
		else if (readLoad)
		begin
			txShift_reg <= readValue;
			sdaOe_reg   <= !readValue[7];
		end
		else if (slotDone)
			sdaOe_reg <= 1'b0;
		else if (sclFall && state_reg == i2c_access_pkg::D_READ && bitCnt_reg != 4'h0)
		begin
			txShift_reg <= {txShift_reg[6:0], 1'b0};
			sdaOe_reg   <= !txShift_reg[6];
		end
	end

	assign link.sdaDevOut = 1'b0;
	assign link.sdaDevOe  = sdaOe_reg;

	// ************************************************************
	// Register space
	// ************************************************************
	always_comb
	begin
		readValue = 8'h00;
		if (ptr_reg == i2c_access_pkg::CTRL_ADDR)
			readValue = ctrl_reg;
		else if (ptr_reg == i2c_access_pkg::REVISION_ADDR)
			readValue = SILICON_REV;
		else if (userHit)
			readValue = user_reg[userOffset[2:0]];
	end

	// Soft reset bit self-clears; the rest of the control byte persists
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			ctrl_reg      <= i2c_access_pkg::CTRL_RESET;
			softPulse_reg <= 1'b0;
		end
		else
		begin
			softPulse_reg <= writeEn && ptr_reg == i2c_access_pkg::CTRL_ADDR
				&& rxShift_reg[i2c_access_pkg::SOFT_RESET_BIT];
			if (writeEn && ptr_reg == i2c_access_pkg::CTRL_ADDR)
				ctrl_reg <= rxShift_reg & ~i2c_access_pkg::SOFT_RESET_MASK;
		end
	end

	// Revision has no write path; unmapped addresses fall through
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			user_reg <= {i2c_access_pkg::USER_COUNT{i2c_access_pkg::USER_RESET}};
		else if (softPulse_reg)
			user_reg <= {i2c_access_pkg::USER_COUNT{i2c_access_pkg::USER_RESET}};
		else if (writeEn && userHit)
			user_reg[userOffset[2:0]] <= rxShift_reg;
	end

	assign controlValue   = ctrl_reg;
	assign softResetPulse = softPulse_reg;
	assign userRegs       = user_reg;
	assign busy           = state_reg != i2c_access_pkg::D_IDLE;
endmodule

// ### src/i2c_port_host.sv
// Bus master that runs one register transfer per command.
// Assumes a single device on the link that never stretches SCL.
`timescale 1ns/1ps
module i2c_port_host #(
	parameter logic [6:0] SLAVE_ADDR = i2c_access_pkg::DEFAULT_SLAVE
) (
	input  wire logic       sys_clk,
	input  wire logic       rst,
	i2c_link_if.host        link,
	input  wire logic [2:0] cpuAddr,
	input  wire logic [7:0] cpuWdata,
	input  wire logic       cpuWrite,
	input  wire logic       cpuRead,
	output logic      [7:0] cpuRdata
);
	// ************************************************************
	// Command registers
	// ************************************************************
	i2c_access_pkg::host_state_t state_reg;
	i2c_access_pkg::host_op_t    op_reg;
	i2c_access_pkg::step_kind_t  stepKind;
	logic [7:0] addrHi_reg;
	logic [7:0] addrLo_reg;
	logic [7:0] wdata_reg;
	logic [7:0] rdata_reg;
	logic       nack_reg;
	logic       launch;
	logic       busy;

	assign busy   = state_reg != i2c_access_pkg::H_IDLE;
	assign launch = cpuWrite && cpuAddr == i2c_access_pkg::HOST_CMD && !busy;

	// Software supplies whole bytes, reserved sections at their defaults
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			op_reg     <= i2c_access_pkg::OP_WRITE;
			addrHi_reg <= 8'h00;
			addrLo_reg <= 8'h00;
			wdata_reg  <= 8'h00;
		end
		else if (cpuWrite && !busy)
		begin
			unique case (cpuAddr)
				i2c_access_pkg::HOST_CMD:    op_reg <= i2c_access_pkg::host_op_t'(cpuWdata[1:0]);
				i2c_access_pkg::HOST_ADDR_H: addrHi_reg <= cpuWdata;
				i2c_access_pkg::HOST_ADDR_L: addrLo_reg <= cpuWdata;
				i2c_access_pkg::HOST_WDATA:  wdata_reg <= cpuWdata;
				default: ;
			endcase
		end
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			cpuRdata <= 8'h00;
		else if (!cpuRead)
			cpuRdata <= 8'h00;
		else if (cpuAddr == i2c_access_pkg::HOST_STATUS)
			cpuRdata <= {6'h00, nack_reg, busy};
		else if (cpuAddr == i2c_access_pkg::HOST_RDATA)
			cpuRdata <= rdata_reg;
		else
			cpuRdata <= 8'h00;
	end

	// ************************************************************
	// Quarter-bit timebase and pin sampling
	// ************************************************************
	logic [15:0] divCnt_reg;
	logic        qTick;
	logic [1:0]  pinSync;

	assign qTick = divCnt_reg == 16'(i2c_access_pkg::QUARTER_CYCLES - 1);

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			divCnt_reg <= 16'h0000;
		else if (qTick || !busy)
			divCnt_reg <= 16'h0000;
		else
			divCnt_reg <= divCnt_reg + 16'h0001;
	end

	sync_two_stage #(
		.WIDTH       (2),
		.RESET_VALUE (2'h3)
	) u_pin_sync (
		.sys_clk (sys_clk),
		.rst     (rst),
		.din     ({link.scl, link.sda}),
		.dout    (pinSync)
	);

	// ************************************************************
	// Transfer plan: which symbol comes at each step of an operation
	// ************************************************************
	logic [2:0] stepIdx_reg;

	always_comb
	begin
		stepKind = i2c_access_pkg::K_STOP;
		unique case (op_reg)
			i2c_access_pkg::OP_WRITE:
				case (stepIdx_reg)
					3'h0: stepKind = i2c_access_pkg::K_SLA_W;
					3'h1: stepKind = i2c_access_pkg::K_ADDR_HI;
					3'h2: stepKind = i2c_access_pkg::K_ADDR_LO;
					3'h3: stepKind = i2c_access_pkg::K_DATA_W;
					default: stepKind = i2c_access_pkg::K_STOP;
				endcase
			i2c_access_pkg::OP_SET_ADDR:
				case (stepIdx_reg)
					3'h0: stepKind = i2c_access_pkg::K_SLA_W;
					3'h1: stepKind = i2c_access_pkg::K_ADDR_HI;
					3'h2: stepKind = i2c_access_pkg::K_ADDR_LO;
					default: stepKind = i2c_access_pkg::K_STOP;
				endcase
			i2c_access_pkg::OP_READ_CUR:
				case (stepIdx_reg)
					3'h0: stepKind = i2c_access_pkg::K_SLA_R;
					3'h1: stepKind = i2c_access_pkg::K_DATA_R;
					default: stepKind = i2c_access_pkg::K_STOP;
				endcase
			i2c_access_pkg::OP_COMBINED:
				case (stepIdx_reg)
					3'h0: stepKind = i2c_access_pkg::K_SLA_W;
					3'h1: stepKind = i2c_access_pkg::K_ADDR_HI;
					3'h2: stepKind = i2c_access_pkg::K_ADDR_LO;
					3'h3: stepKind = i2c_access_pkg::K_RSTART;
					3'h4: stepKind = i2c_access_pkg::K_SLA_R;
					3'h5: stepKind = i2c_access_pkg::K_DATA_R;
					default: stepKind = i2c_access_pkg::K_STOP;
				endcase
		endcase
	end

	// ************************************************************
	// Line sequencer: four quarters per bit, start and stop
	// ************************************************************
	logic [1:0] quarter_reg;
	logic [3:0] bit_reg;
	logic [7:0] tx_reg;
	logic [7:0] rx_reg;
	logic       readByte_reg;
	logic       ackIn_reg;
	logic       sclLow_reg;
	logic       sdaLow_reg;
	logic       phaseEnd;

	assign phaseEnd = qTick && quarter_reg == 2'h3
		&& (state_reg != i2c_access_pkg::H_BIT || bit_reg == i2c_access_pkg::BITS_PER_BYTE);

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			state_reg    <= i2c_access_pkg::H_IDLE;
			stepIdx_reg  <= 3'h0;
			quarter_reg  <= 2'h0;
			bit_reg      <= 4'h0;
			tx_reg       <= 8'h00;
			rx_reg       <= 8'h00;
			readByte_reg <= 1'b0;
			ackIn_reg    <= 1'b1;
			sclLow_reg   <= 1'b0;
			sdaLow_reg   <= 1'b0;
			nack_reg     <= 1'b0;
			rdata_reg    <= 8'h00;
		end
		else if (launch)
		begin
			state_reg   <= i2c_access_pkg::H_START;
			stepIdx_reg <= 3'h0;
			quarter_reg <= 2'h0;
			nack_reg    <= 1'b0;
		end
		else if (qTick)
		begin
			quarter_reg <= quarter_reg + 2'h1;
			unique case (state_reg)
				i2c_access_pkg::H_START:
					unique case (quarter_reg)
						2'h0: sdaLow_reg <= 1'b0;
						2'h1: sclLow_reg <= 1'b0;
						2'h2: sdaLow_reg <= 1'b1;
						2'h3: sclLow_reg <= 1'b1;
					endcase
				i2c_access_pkg::H_BIT:
					unique case (quarter_reg)
						2'h0: sdaLow_reg <= bit_reg == i2c_access_pkg::BITS_PER_BYTE
							? 1'b0 : !readByte_reg && !tx_reg[7];
						2'h1: sclLow_reg <= 1'b0;
						2'h2:
							if (bit_reg == i2c_access_pkg::BITS_PER_BYTE)
								ackIn_reg <= pinSync[0];
							else
								rx_reg <= {rx_reg[6:0], pinSync[0]};
						2'h3:
						begin
							sclLow_reg <= 1'b1;
							tx_reg     <= {tx_reg[6:0], 1'b0};
							bit_reg    <= bit_reg + 4'h1;
						end
					endcase
				i2c_access_pkg::H_STOP:
					unique case (quarter_reg)
						2'h0: sdaLow_reg <= 1'b1;
						2'h1: sclLow_reg <= 1'b0;
						2'h2: sdaLow_reg <= 1'b0;
						2'h3: state_reg <= i2c_access_pkg::H_IDLE;
					endcase
				default: ;
			endcase
			if (phaseEnd && state_reg != i2c_access_pkg::H_STOP)
			begin
				bit_reg     <= 4'h0;
				stepIdx_reg <= stepIdx_reg + 3'h1;
				if (state_reg == i2c_access_pkg::H_BIT && readByte_reg)
					rdata_reg <= rx_reg;
				// A refused byte ends the transfer with a stop
				if (state_reg == i2c_access_pkg::H_BIT && !readByte_reg && ackIn_reg)
				begin
					nack_reg  <= 1'b1;
					state_reg <= i2c_access_pkg::H_STOP;
				end
				else
				begin
					readByte_reg <= stepKind == i2c_access_pkg::K_DATA_R;
					unique case (stepKind)
						i2c_access_pkg::K_SLA_W:   tx_reg <= {SLAVE_ADDR, 1'b0};
						i2c_access_pkg::K_SLA_R:   tx_reg <= {SLAVE_ADDR, 1'b1};
						i2c_access_pkg::K_ADDR_HI: tx_reg <= addrHi_reg;
						i2c_access_pkg::K_ADDR_LO: tx_reg <= addrLo_reg;
						i2c_access_pkg::K_DATA_W:  tx_reg <= wdata_reg;
						default:                   tx_reg <= 8'hFF;
					endcase
					if (stepKind == i2c_access_pkg::K_RSTART)
						state_reg <= i2c_access_pkg::H_START;
					else if (stepKind == i2c_access_pkg::K_STOP)
						state_reg <= i2c_access_pkg::H_STOP;
					else
						state_reg <= i2c_access_pkg::H_BIT;
				end
			end
		end
	end

	assign link.sclHostOut = 1'b0;
	assign link.sclHostOe  = sclLow_reg;
	assign link.sdaHostOut = 1'b0;
	assign link.sdaHostOe  = sdaLow_reg;
endmodule

// ### test/i2c_port_properties.sv
// Wire checker for the link joining the two ends.
// Assumes one sys_clk domain and resolved line levels.
`timescale 1ns/1ps
module i2c_port_properties (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic scl,
	input wire logic sda,
	input wire logic sdaHostOe,
	input wire logic sdaDevOe
);
	int unsigned runCnt;

	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);

	// ****************
	// Helper
	// ****************
	// Longest legal pull: ack plus eight low read bits
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			runCnt <= 0;
		else if (sdaDevOe)
			runCnt <= runCnt + 1;
		else
			runCnt <= 0;
	end

	// ****************
	// Properties
	// ****************
	property p_devStable;
		scl && $past(scl) |-> $stable(sdaDevOe);
	endproperty
	a_devStable: assert property (p_devStable) else $error("device changed sda while scl high");
	property p_devRun;
		runCnt < 4600;
	endproperty
	a_devRun: assert property (p_devRun) else $error("device held sda too long");
	property p_stopFree;
		scl && $past(scl) && $rose(sda) |-> !sdaDevOe [*8];
	endproperty
	a_stopFree: assert property (p_stopFree) else $error("device drove after stop");
	property p_startFree;
		scl && $past(scl) && $fell(sda) |=> !sdaDevOe [*8];
	endproperty
	a_startFree: assert property (p_startFree) else $error("device drove after start");
	property p_riseLow;
		$rose(sdaDevOe) |-> !scl;
	endproperty
	a_riseLow: assert property (p_riseLow) else $error("device pulled sda with scl high");
	property p_ackHold;
		$rose(sdaDevOe) |-> sdaDevOe throughout (##[1:300] $rose(scl));
	endproperty
	a_ackHold: assert property (p_ackHold) else $error("device pull dropped before scl rose");
	property p_soleDriver;
		$rose(scl) && sdaDevOe |-> !sdaHostOe;
	endproperty
	a_soleDriver: assert property (p_soleDriver) else $error("both ends drove sda");
	property p_sclHigh;
		$rose(scl) |-> scl [*8];
	endproperty
	a_sclHigh: assert property (p_sclHigh) else $error("scl high phase too short");
endmodule

// ### test/test_i2c_register_access_port.sv
// Bench joining bus master and register port over one link.
// Assumes the package quarter count of 125 clocks.
`timescale 1ns/1ps
module test_i2c_register_access_port;
	localparam logic [7:0] REV = 8'hA5; // Arbitrary value
	logic                  sys_clk   = 1'b0;
	logic                  rst       = 1'b1;
	logic [2:0]            cpuAddr   = 3'h0;
	logic [7:0]            cpuWdata  = 8'h00;
	logic                  cpuWrite  = 1'b0;
	logic                  cpuRead   = 1'b0;
	logic                  chkOn     = 1'b0;
	logic                  rdSeen    = 1'b0;
	logic [7:0]            srCount   = 8'h00;
	logic [7:0]            cpuRdata;
	logic [7:0]            controlValue;
	logic [7:0]            r1;
	logic [7:0]            expQ[$];
	logic                  srPulse;
	logic                  devBusy;
	logic [i2c_access_pkg::USER_COUNT-1:0][7:0] userRegs;
	int                    nErrors   = 0;
	int                    cmpCount  = 0;
	int                    cycles    = 0;

	i2c_link_if link();
	i2c_port_device #(.SILICON_REV(REV)) i_i2c_port_device (.sys_clk(sys_clk), .rst(rst), .link(link),
		.controlValue(controlValue), .softResetPulse(srPulse), .userRegs(userRegs), .busy(devBusy));
	i2c_port_host i_i2c_port_host (.sys_clk(sys_clk), .rst(rst), .link(link), .cpuAddr(cpuAddr),
		.cpuWdata(cpuWdata), .cpuWrite(cpuWrite), .cpuRead(cpuRead), .cpuRdata(cpuRdata));
	i2c_port_properties i_i2c_port_properties (.sys_clk(sys_clk), .rst(rst), .scl(link.scl), .sda(link.sda),
		.sdaHostOe(link.sdaHostOe), .sdaDevOe(link.sdaDevOe));

	always #10 sys_clk = ~sys_clk;

	// ****************
	// Tasks
	// ****************
	task automatic printVerdict;
		$display("comparisons %0d mismatches %0d", cmpCount, nErrors);
		if (nErrors == 0 && cmpCount > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic check8(input string name, input logic [7:0] exp, input logic [7:0] got);
		cmpCount++;
		if (got !== exp)
		begin
			nErrors++;
			$display("unexpected %s: expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic cpuWr(input logic [2:0] a, input logic [7:0] d);
		cpuAddr <= a;
		cpuWdata <= d;
		cpuWrite <= 1'b1;
		cpuRead <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic cpuRd(input logic [2:0] a, input logic chk, input logic [7:0] exp);
		cpuAddr <= a;
		cpuRead <= 1'b1;
		cpuWrite <= 1'b0;
		chkOn <= chk;
		if (chk)
			expQ.push_back(exp);
		@(posedge sys_clk);
	endtask

	// Polls every other cycle; the global counter bounds a hang
	task automatic runOp(input logic [1:0] op, input logic [15:0] a, input logic [7:0] d);
		logic [7:0] s;
		cpuWr(i2c_access_pkg::HOST_ADDR_H, a[15:8]);
		cpuWr(i2c_access_pkg::HOST_ADDR_L, a[7:0]);
		cpuWr(i2c_access_pkg::HOST_WDATA, d);
		cpuWr(i2c_access_pkg::HOST_CMD, {6'h00, op});
		s = 8'h01;
		while (s[0] !== 1'b0)
		begin
			cpuRd(i2c_access_pkg::HOST_STATUS, 1'b0, 8'h00);
			cpuRead <= 1'b0;
			@(negedge sys_clk);
			s = cpuRdata;
			@(posedge sys_clk);
		end
		check8("nack", 8'h00, {7'h00, s[1]});
	endtask

	task automatic readData(input logic [7:0] exp);
		cpuRd(i2c_access_pkg::HOST_RDATA, 1'b1, exp);
		cpuRead <= 1'b0;
		chkOn <= 1'b0;
		@(posedge sys_clk);
	endtask

	// ****************
	// Monitor
	// ****************
	always @(posedge sys_clk)
	begin
		rdSeen <= cpuRead && chkOn;
		if (srPulse === 1'b1)
			srCount <= srCount + 8'h01;
		cycles <= cycles + 1;
		if (cycles == 95000)
		begin
			nErrors++;
			printVerdict();
		end
	end

	always @(negedge sys_clk)
		if (rdSeen)
			check8("rdata", expQ.pop_front(), cpuRdata);

	// ****************
	// Sequence
	// ****************
	initial
	begin
		r1 = 8'($urandom(32'h16B3144B));
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		r1 = 8'($urandom);
		runOp(2'h0, 16'h0012, r1);
		check8("user2", r1, userRegs[2]);
		runOp(2'h1, 16'h0012, ~r1);
		check8("user2", r1, userRegs[2]);
		check8("user3", 8'h00, userRegs[3]);
		runOp(2'h2, 16'h0000, 8'h00);
		readData(r1);
		check8("busy", 8'h00, {7'h00, devBusy});
		runOp(2'h3, i2c_access_pkg::REVISION_ADDR, 8'h00);
		readData(REV);
		runOp(2'h0, i2c_access_pkg::CTRL_ADDR, 8'h90);
		check8("control", 8'h80, controlValue);
		check8("user2", 8'h00, userRegs[2]);
		check8("pulses", 8'h01, srCount);
		printVerdict();
	end
endmodule
